/* verilog/anxnp_pkg.sv */
// constants for the expansion and next-page register group
// shared by the register block and its verification environment
package anxnp_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int CODE_W = 11;
   localparam int IRQ_W  = 3;

   // register offsets (word addresses of the management space)
   localparam logic [ADDR_W-1:0] OFS_EXPANSION = 5'h06;
   localparam logic [ADDR_W-1:0] OFS_NP_TX     = 5'h07;
   localparam logic [ADDR_W-1:0] OFS_NP_RX     = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 5'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR   = 5'h19;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 5'h1a;

   // expansion register bits
   localparam int EXP_BASE_PAGE   = 5;
   localparam int EXP_PAR_FAULT   = 4;
   localparam int EXP_PARTNER_NP  = 3;
   localparam int EXP_LOCAL_NP    = 2;
   localparam int EXP_PAGE_RX     = 1;
   localparam int EXP_PARTNER_AN  = 0;

   // next-page word bits (same layout for transmit and receive)
   localparam int NP_MORE_PAGES   = 15;
   localparam int NP_ACK          = 14;
   localparam int NP_MESSAGE      = 13;
   localparam int NP_COMPLY       = 12;
   localparam int NP_TOGGLE       = 11;
   localparam int NP_CODE_LSB     = 0;

   // interrupt status bits
   localparam int IRQ_PAGE_RX     = 0;
   localparam int IRQ_PAR_FAULT   = 1;
   localparam int IRQ_NP_LOADED   = 2;

   // reset values
   localparam logic              RST_LOCAL_NP  = 1'b1;
   localparam logic              RST_MORE      = 1'b0;
   localparam logic              RST_MESSAGE   = 1'b1;
   localparam logic              RST_COMPLY    = 1'b0;
   localparam logic              RST_TOGGLE    = 1'b0;
   localparam logic [CODE_W-1:0] RST_TX_CODE   = 11'h001;
   localparam logic [DATA_W-1:0] RST_RX_WORD   = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_ZERO     = 16'h0000;
   localparam logic [IRQ_W-1:0]  IRQ_ZERO      = 3'h0;
endpackage : anxnp_pkg

/* verilog/anxnp_regs.sv */
// expansion, transmit next-page and partner next-page registers
// assumes negotiation logic drives its status levels and pulses on clk_sys_i
//
// Summary of operation
// - base-page variable latched high, alternate option only
// - parallel detection fault latches high, reset zero
// - partner next-page ability read-only, reset zero
// - local next-page ability read-only, reset one
// - page-received set when code word stored
// - reading expansion register clears page-received
// - alternate option: clear on page_rx low/tx disable
// - partner negotiation ability read-only, reset zero
// - writable more-pages flag, reset zero
// - reserved transmit bit reads zero, writes ignored
// - writable message-page flag, reset one
// - writable comply flag, reset zero
// - toggle bit inverts previous transmitted value
// - partner more-pages flag read-only, reset zero
// - partner acknowledge flag read-only
// - partner message-page flag read-only
// - partner comply flag read-only
`timescale 1ns/1ps
module anxnp_regs (
   input  wire logic                           clk_sys_i,
   input  wire logic                           reset_n_i,
   input  wire logic [anxnp_pkg::ADDR_W-1:0]   addr_i,
   input  wire logic [anxnp_pkg::DATA_W-1:0]   wdata_i,
   input  wire logic                           wr_i,
   input  wire logic                           rd_i,
   output logic      [anxnp_pkg::DATA_W-1:0]   rdata_o,
   input  wire logic                           alt_next_page_option_i,
   input  wire logic                           transmit_disable_i,
   input  wire logic                           mr_page_rx_i,
   input  wire logic                           base_page_i,
   input  wire logic                           par_fault_i,
   input  wire logic                           partner_np_able_i,
   input  wire logic                           local_np_able_i,
   input  wire logic                           partner_an_able_i,
   input  wire logic                           page_stored_i,
   input  wire logic                           rx_np_load_i,
   input  wire logic [anxnp_pkg::DATA_W-1:0]   rx_np_word_i,
   input  wire logic                           tx_np_sent_i,
   output logic      [anxnp_pkg::DATA_W-1:0]   tx_np_word_o,
   output logic                                irq_o
);
   import anxnp_pkg::*;

   typedef struct packed {
      logic              base_page;
      logic              par_fault;
      logic              partner_np;
      logic              local_np;
      logic              page_rx;
      logic              partner_an;
      logic              more_pages_follow;
      logic              message_page_flag;
      logic              will_comply_flag;
      logic              tx_toggle;
      logic [CODE_W-1:0] tx_code;
      logic [DATA_W-1:0] rx_word;
      logic [IRQ_W-1:0]  irq_stat;
      logic [IRQ_W-1:0]  irq_en;
      logic [DATA_W-1:0] rdata;
      logic              irq;
   } anxnp_state_s;

   anxnp_state_s st;
   anxnp_state_s next_st;

   logic              rd_exp;
   logic              alt_clear;
   logic [DATA_W-1:0] exp_word;
   logic [DATA_W-1:0] tx_word;
   logic [IRQ_W-1:0]  irq_set;

   always_comb begin
      exp_word                 = DATA_ZERO;
      exp_word[EXP_BASE_PAGE]  = st.base_page;
      exp_word[EXP_PAR_FAULT]  = st.par_fault;
      exp_word[EXP_PARTNER_NP] = st.partner_np;
      exp_word[EXP_LOCAL_NP]   = st.local_np;
      exp_word[EXP_PAGE_RX]    = st.page_rx;
      exp_word[EXP_PARTNER_AN] = st.partner_an;

      tx_word                  = DATA_ZERO;
      tx_word[NP_MORE_PAGES]   = st.more_pages_follow;
      tx_word[NP_MESSAGE]      = st.message_page_flag;
      tx_word[NP_COMPLY]       = st.will_comply_flag;
      tx_word[NP_TOGGLE]       = st.tx_toggle;
      tx_word[NP_CODE_LSB +: CODE_W] = st.tx_code;
   end

   always_comb begin
      next_st   = st;
      rd_exp    = rd_i && (addr_i == OFS_EXPANSION);
      alt_clear = alt_next_page_option_i && (!mr_page_rx_i || transmit_disable_i);

      // latched bits: a read shows the latch, then the current level; set wins
      if (rd_exp) begin
         next_st.base_page = base_page_i && alt_next_page_option_i;
         next_st.par_fault = par_fault_i;
      end
      if (base_page_i && alt_next_page_option_i) begin
         next_st.base_page = 1'b1;
      end
      if (par_fault_i) begin
         next_st.par_fault = 1'b1;
      end

      next_st.partner_np = partner_np_able_i;
      next_st.local_np   = local_np_able_i;
      next_st.partner_an = partner_an_able_i;

      if (rd_exp) begin
         next_st.page_rx = 1'b0;
      end
      if (alt_clear) begin
         next_st.page_rx = 1'b0;
      end
      if (page_stored_i) begin
         next_st.page_rx = 1'b1;
      end

      if (rx_np_load_i) begin
         next_st.rx_word = rx_np_word_i;
      end

      if (wr_i && (addr_i == OFS_NP_TX)) begin
         next_st.more_pages_follow = wdata_i[NP_MORE_PAGES];
         next_st.message_page_flag = wdata_i[NP_MESSAGE];
         next_st.will_comply_flag  = wdata_i[NP_COMPLY];
         next_st.tx_toggle         = wdata_i[NP_TOGGLE];
         next_st.tx_code           = wdata_i[NP_CODE_LSB +: CODE_W];
      end
      // hardware flip after each sent word beats a software write
      if (tx_np_sent_i) begin
         next_st.tx_toggle = !st.tx_toggle;
      end

      irq_set                = IRQ_ZERO;
      irq_set[IRQ_PAGE_RX]   = page_stored_i;
      irq_set[IRQ_PAR_FAULT] = par_fault_i;
      irq_set[IRQ_NP_LOADED] = rx_np_load_i;
      if (wr_i && (addr_i == OFS_IRQ_CLR)) begin
         next_st.irq_stat = st.irq_stat & ~wdata_i[IRQ_W-1:0];
      end
      next_st.irq_stat = next_st.irq_stat | irq_set;
      if (wr_i && (addr_i == OFS_IRQ_EN)) begin
         next_st.irq_en = wdata_i[IRQ_W-1:0];
      end
      next_st.irq = |(next_st.irq_stat & next_st.irq_en);

      // read data stands only in the cycle after the strobe
      next_st.rdata = DATA_ZERO;
      if (rd_i) begin
         if (addr_i == OFS_EXPANSION) begin
            next_st.rdata = exp_word;
         end else if (addr_i == OFS_NP_TX) begin
            next_st.rdata = tx_word;
         end else if (addr_i == OFS_NP_RX) begin
            next_st.rdata = st.rx_word;
         end else if (addr_i == OFS_IRQ_STAT) begin
            next_st.rdata[IRQ_W-1:0] = st.irq_stat;
         end else if (addr_i == OFS_IRQ_EN) begin
            next_st.rdata[IRQ_W-1:0] = st.irq_en;
         end else begin
            next_st.rdata = DATA_ZERO;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st                   <= '0;
         st.local_np          <= RST_LOCAL_NP;
         st.more_pages_follow <= RST_MORE;
         st.message_page_flag <= RST_MESSAGE;
         st.will_comply_flag  <= RST_COMPLY;
         st.tx_toggle         <= RST_TOGGLE;
         st.tx_code           <= RST_TX_CODE;
         st.rx_word           <= RST_RX_WORD;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      rdata_o      = st.rdata;
      irq_o        = st.irq;
   end

   // transmit word leaves straight from the register bits
   assign tx_np_word_o = {st.more_pages_follow, 1'b0, st.message_page_flag,
                          st.will_comply_flag, st.tx_toggle, st.tx_code};
endmodule : anxnp_regs

/* test/anxnp_regs_monitor.sv */
// checker for the expansion and next-page register ports
// assumes one clock domain, attached to anxnp_regs by the bind below
`timescale 1ns/1ps
module anxnp_regs_monitor (
   input wire logic        clk_sys_i,
   input wire logic        reset_n_i,
   input wire logic [4:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic        par_fault_i,
   input wire logic        partner_np_able_i,
   input wire logic        page_stored_i,
   input wire logic        rx_np_load_i,
   input wire logic [15:0] rx_np_word_i,
   input wire logic        tx_np_sent_i,
   input wire logic [15:0] tx_np_word_o
);
   import anxnp_pkg::*;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   sequence rd_exp;
      rd_i && addr_i == OFS_EXPANSION;
   endsequence
   tx_rsvd_a: assert property (tx_np_word_o[NP_ACK] == 1'b0)
      else $error("reserved bit set");
   page_set_a: assert property (page_stored_i ##1 rd_exp |=> rdata_o[EXP_PAGE_RX])
      else $error("page received not set");
   page_clear_a: assert property (
      rd_exp ##0 !page_stored_i [*2] ##1 rd_exp |=> !rdata_o[EXP_PAGE_RX])
      else $error("page received not cleared");
   fault_set_a: assert property (par_fault_i ##1 rd_exp |=> rdata_o[EXP_PAR_FAULT])
      else $error("fault not latched");
   tx_write_a: assert property (wr_i && addr_i == OFS_NP_TX && !tx_np_sent_i
      |=> tx_np_word_o == ($past(wdata_i) & 16'hbfff)) else $error("tx word wrong");
   toggle_flip_a: assert property (tx_np_sent_i |=> tx_np_word_o[11] != $past(tx_np_word_o[11]))
      else $error("toggle not flipped");
   tx_hold_a: assert property (!wr_i && !tx_np_sent_i |=> $stable(tx_np_word_o))
      else $error("tx word moved");
   rx_word_a: assert property (rx_np_load_i ##1 (rd_i && addr_i == OFS_NP_RX)
      |=> rdata_o == $past(rx_np_word_i, 2)) else $error("rx word wrong");
   partner_np_a: assert property ($past(reset_n_i) ##0 rd_exp |=> rdata_o[15:6] == 10'h000
      && rdata_o[EXP_PARTNER_NP] == $past(partner_np_able_i, 2)) else $error("exp level wrong");
endmodule : anxnp_regs_monitor
bind anxnp_regs anxnp_regs_monitor i_mon (.*);

/* test/anxnp_partner.sv */
// remote link partner model: hands received pages to the register block
// assumes the block clock; outputs change just after rising edges
`timescale 1ns/1ps
module anxnp_partner (
   input  wire logic  clk_sys_i,
   output logic       page_stored_o,
   output logic       rx_np_load_o,
   output logic [15:0] rx_np_word_o,
   output logic       partner_np_able_o,
   output logic       partner_an_able_o
);
   import anxnp_pkg::*;
   initial {page_stored_o, rx_np_load_o, rx_np_word_o, partner_np_able_o, partner_an_able_o} = '0;
   // word shows its inverse once the load cycle is over
   task send(input logic [15:0] w);
      partner_an_able_o <= 1'b1;
      partner_np_able_o <= w[NP_MORE_PAGES];
      rx_np_word_o      <= w;
      rx_np_load_o      <= 1'b1;
      page_stored_o     <= 1'b1;
      @(posedge clk_sys_i);
      rx_np_load_o      <= 1'b0;
      page_stored_o     <= 1'b0;
      rx_np_word_o      <= ~w;
   endtask : send
endmodule : anxnp_partner

/* test/anxnp_regs_test.sv */
// self-checking bench for the expansion and next-page registers
// assumes the partner model supplies received pages, bench drives the bus
`timescale 1ns/1ps
module anxnp_regs_test;
   import anxnp_pkg::*;
   logic        clk_sys_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic        alt_next_page_option_i = 1'b0, transmit_disable_i = 1'b0, mr_page_rx_i = 1'b1;
   logic        base_page_i = 1'b0, par_fault_i = 1'b0, local_np_able_i = 1'b1, tx_np_sent_i = 1'b0;
   logic [4:0]  addr_i = 5'h00;
   logic [15:0] wdata_i = 16'h0000, rdata_o, tx_np_word_o, rx_np_word_i;
   logic        irq_o, page_stored_i, rx_np_load_i, partner_np_able_i, partner_an_able_i;
   int          err_count = 0, num_checks = 0;
   anxnp_regs i_dut (.*);
   anxnp_partner p (.clk_sys_i, .page_stored_o(page_stored_i), .rx_np_load_o(rx_np_load_i),
      .rx_np_word_o(rx_np_word_i), .partner_np_able_o(partner_np_able_i),
      .partner_an_able_o(partner_an_able_i));
   initial forever #50 clk_sys_i = ~clk_sys_i;
   task chk(input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [15:0] d);
      wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : wr
   task rd(input logic [4:0] a, input logic [15:0] e);
      rd_i <= 1'b1; addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
      @(posedge clk_sys_i);
   endtask : rd
   task pulse_sent;
      tx_np_sent_i <= 1'b1;
      @(posedge clk_sys_i);
      tx_np_sent_i <= 1'b0;
   endtask : pulse_sent
   task t_reset;
      #1 chk(tx_np_word_o, 16'h2001);
      @(posedge clk_sys_i);
      rd(OFS_EXPANSION, 16'h0004);
      rd(OFS_NP_RX, 16'h0000);
   endtask : t_reset
   task t_tx;
      wr(OFS_NP_TX, 16'hbfff);
      rd(OFS_NP_TX, 16'hbfff);
      pulse_sent;
      rd(OFS_NP_TX, 16'hb7ff);
      wr(OFS_NP_TX, 16'h0000);
      rd(OFS_NP_TX, 16'h0000);
   endtask : t_tx
   task t_rx;
      p.send(16'hd5aa);
      rd(OFS_NP_RX, 16'hd5aa);
      rd(OFS_EXPANSION, 16'h000f);
      rd(OFS_EXPANSION, 16'h000d);
      rd(5'h1f, 16'h0000);
      // read clear and a new page in one cycle: the new page wins
      fork
         p.send(16'h8abc);
         rd(OFS_EXPANSION, 16'h000d);
      join
      rd(OFS_EXPANSION, 16'h000f);
   endtask : t_rx
   task t_latch;
      alt_next_page_option_i <= 1'b1; base_page_i <= 1'b1; par_fault_i <= 1'b1;
      @(posedge clk_sys_i);
      base_page_i <= 1'b0; par_fault_i <= 1'b0;
      rd(OFS_EXPANSION, 16'h003d);
      rd(OFS_EXPANSION, 16'h000d);
      p.send(16'h0123);
      mr_page_rx_i <= 1'b0;
      @(posedge clk_sys_i);
      mr_page_rx_i <= 1'b1;
      rd(OFS_EXPANSION, 16'h0005);
      p.send(16'h4002);
      transmit_disable_i <= 1'b1;
      @(posedge clk_sys_i);
      transmit_disable_i <= 1'b0;
      rd(OFS_EXPANSION, 16'h0005);
      // option off: no base-page latch; transmitter disable falls in the store cycle, where the set wins anyway
      alt_next_page_option_i <= 1'b0; base_page_i <= 1'b1; transmit_disable_i <= 1'b1;
      p.send(16'h0123);
      base_page_i <= 1'b0; transmit_disable_i <= 1'b0;
      rd(OFS_EXPANSION, 16'h0007);
   endtask : t_latch
   task t_irq;
      wr(OFS_IRQ_CLR, 16'h0007);
      wr(OFS_IRQ_EN, 16'h0001);
      #1 chk({15'h0000, irq_o}, 16'h0000);
      @(posedge clk_sys_i);
      p.send(16'h8001);
      #1 chk({15'h0000, irq_o}, 16'h0001);
      @(posedge clk_sys_i);
      rd(OFS_IRQ_STAT, 16'h0005);
      rd(OFS_IRQ_EN, 16'h0001);
      wr(OFS_IRQ_CLR, 16'h0001);
      #1 chk({15'h0000, irq_o}, 16'h0000);
      @(posedge clk_sys_i);
      rd(OFS_IRQ_CLR, 16'h0000);
      wr(OFS_IRQ_EN, 16'h0000);
      p.send(16'h8001);
      #1 chk({15'h0000, irq_o}, 16'h0000);
      @(posedge clk_sys_i);
   endtask : t_irq
   task t_mid_reset;
      wr(OFS_NP_TX, 16'h9a55);
      local_np_able_i <= 1'b0;
      reset_n_i <= 1'b0;
      @(posedge clk_sys_i);
      #1 chk(tx_np_word_o, 16'h2001);
      chk({15'h0000, irq_o}, 16'h0000);
      @(posedge clk_sys_i);
      // release and first read together: the read shows the reset values
      reset_n_i <= 1'b1;
      rd(OFS_EXPANSION, 16'h0004);
      rd(OFS_NP_RX, 16'h0000);
      rd(OFS_EXPANSION, 16'h0009);
      local_np_able_i <= 1'b1;
   endtask : t_mid_reset
   task results;
      if (err_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   initial begin
      repeat (4) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      @(posedge clk_sys_i);
      t_reset;
      t_tx;
      t_rx;
      t_latch;
      t_irq;
      t_mid_reset;
      results;
   end
endmodule : anxnp_regs_test
